/* core/switch_pkg.sv */
// Shared constants and types for the octal switch fault and shutdown logic.
package switch_pkg;

  localparam int NUM_OUT   = 8;
  localparam int WORD_BITS = 8;

  // clock and timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int BLANK_DELAY_NS = 25000;
  localparam int BLANK_CYCLES_I = (BLANK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W        = 10;
  localparam logic [TIMER_W-1:0] BLANK_CYCLES = TIMER_W'(BLANK_CYCLES_I);

  // reset values
  localparam logic [WORD_BITS-1:0] CMD_ALL_OFF    = 8'hFF;
  localparam logic [WORD_BITS-1:0] STATUS_ALL_OFF = 8'hFF;

  // field positions in the synchronised input vector
  localparam int SYNC_W    = 22;
  localparam int POS_CS_N  = 21;
  localparam int POS_SCLK  = 20;
  localparam int POS_SI    = 19;
  localparam int POS_SFSEL = 18;
  localparam int POS_LUV   = 17;
  localparam int POS_LOV   = 16;
  localparam int POS_DRAIN = 8;
  localparam int POS_TEMP  = 0;
  // chip select idles high so reset must not look like a frame start
  localparam logic [SYNC_W-1:0] SYNC_RESET = 22'h200000;

  localparam logic [2:0] BIT_CNT_LAST = 3'h7;

  typedef enum logic {
    FRAME_IDLE   = 1'b0,
    FRAME_ACTIVE = 1'b1
  } frame_t;

endpackage

/* core/sync2.sv */
// Two flip-flop synchroniser for a vector of asynchronous levels.
module sync2 #(
  parameter int                  W         = 1,
  parameter logic [W-1:0]        RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= RESET_VAL;
      stable_q <= RESET_VAL;
    end else begin
      meta_q   <= d;
      stable_q <= meta_q;
    end
  end

  assign q = stable_q;

endmodule

/* core/blank_timer.sv */
// Retriggerable delay timer: running for the blanking time after start.
module blank_timer (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      running
);
  import switch_pkg::*;

  logic [TIMER_W-1:0] cnt_q;
  logic [TIMER_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = BLANK_CYCLES;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - TIMER_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign running = (cnt_q != '0);

endmodule

/* core/octal_switch_fault_shutdown.sv */
// Per-output short, thermal and supply shutdown for an eight-channel switch.
//
// Contract
// - select rising edge turns on commanded outputs and starts per-output blanking timer
// - shutdown mode: short present at turn-on holds output on for blanking, then off
// - shutdown mode: short during blanking shuts down only once blanking expires
// - shutdown mode: short after blanking turns output off immediately
// - select high: overcurrent never disables output, it goes current-limited instead
// - select governs all eight outputs alike, each keeps its own shutdown latch
// - thermal and overvoltage shutdown ignore the short-fault select level
// - select high: output recovers by itself when short goes, unless thermally latched
// - shutdown mode: after short shutdown output stays off until next write
// - shutdown mode: with a persistent short each write commanding on retries for blanking then off
// - logic undervoltage switches all outputs off, status register reads all off
// - load undervoltage causes no shutdown, outputs keep following command word
// - load overvoltage turns all outputs off, latched until a new command word
// - overcurrent and thermal faults report the same status bit value
// - enabled output with drain above threshold is a short
// - command bit high disables output, open load checked on disabled outputs only
// - after overvoltage the next write shifts out all ones
// - open-load results ignored until fault delay timer from select rise elapses
module octal_switch_fault_shutdown (
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  input  wire logic                          CHIP_SELECT_N,
  input  wire logic                          SCLK,
  input  wire logic                          SI,
  output logic                               SO,
  output logic                               SO_OE,
  input  wire logic                          SHORT_FAULT_SHUTDOWN_SELECT,
  input  wire logic [switch_pkg::NUM_OUT-1:0] DRAIN_ABOVE_FAULT_THRESHOLD,
  input  wire logic [switch_pkg::NUM_OUT-1:0] OVER_TEMP,
  input  wire logic                          LOGIC_UNDERVOLTAGE,
  input  wire logic                          LOAD_OVERVOLTAGE,
  output logic      [switch_pkg::NUM_OUT-1:0] GATE_ON,
  output logic      [switch_pkg::NUM_OUT-1:0] CURRENT_LIMIT
);
  import switch_pkg::*;

  // synchronised pins
  logic [SYNC_W-1:0]  raw_in;
  logic [SYNC_W-1:0]  sync_in;
  logic               cs_n_s;
  logic               sclk_s;
  logic               si_s;
  logic               sfsel_s;
  logic               luv_s;
  logic               lov_s;
  logic [NUM_OUT-1:0] drain_s;
  logic [NUM_OUT-1:0] temp_s;

  // link state
  frame_t               frame_q;
  frame_t               frame_d;
  logic [WORD_BITS-1:0] sr_q;
  logic [WORD_BITS-1:0] sr_d;
  logic [2:0]           cnt_q;
  logic [2:0]           cnt_d;
  logic                 word_q;
  logic                 word_d;
  logic                 cs_prev_q;
  logic                 cs_prev_d;
  logic                 sclk_prev_q;
  logic                 sclk_prev_d;
  logic                 so_q;
  logic                 so_d;
  logic                 so_oe_q;
  logic                 so_oe_d;
  logic                 cs_fall;
  logic                 cs_rise;
  logic                 sclk_rise;
  logic                 sclk_fall;
  logic                 cmd_write;
  logic [WORD_BITS-1:0] status_word;

  // output control state
  logic [NUM_OUT-1:0] cmd_q;
  logic [NUM_OUT-1:0] cmd_d;
  logic [NUM_OUT-1:0] short_q;
  logic [NUM_OUT-1:0] short_d;
  logic [NUM_OUT-1:0] therm_q;
  logic [NUM_OUT-1:0] therm_d;
  logic               ov_q;
  logic               ov_d;
  logic [NUM_OUT-1:0] gate_q;
  logic [NUM_OUT-1:0] gate_d;
  logic [NUM_OUT-1:0] ilim_q;
  logic [NUM_OUT-1:0] ilim_d;
  logic [NUM_OUT-1:0] blank_start;
  logic [NUM_OUT-1:0] blank_run;
  logic               fault_start;
  logic               fault_run;

  assign raw_in = {CHIP_SELECT_N, SCLK, SI, SHORT_FAULT_SHUTDOWN_SELECT,
                   LOGIC_UNDERVOLTAGE, LOAD_OVERVOLTAGE,
                   DRAIN_ABOVE_FAULT_THRESHOLD, OVER_TEMP};

  // every pin passes two flops; select and clock edges are found on the synced copies
  sync2 #(
    .W         (SYNC_W),
    .RESET_VAL (SYNC_RESET)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     (raw_in),
    .q     (sync_in)
  );

  assign cs_n_s  = sync_in[POS_CS_N];
  assign sclk_s  = sync_in[POS_SCLK];
  assign si_s    = sync_in[POS_SI];
  assign sfsel_s = sync_in[POS_SFSEL];
  assign luv_s   = sync_in[POS_LUV];
  assign lov_s   = sync_in[POS_LOV];
  assign drain_s = sync_in[POS_DRAIN +: NUM_OUT];
  assign temp_s  = sync_in[POS_TEMP +: NUM_OUT];

  // edge of a synchronised level against its value one clock earlier
  function automatic logic level_rise(input logic prev, input logic now);
    return ~prev & now;
  endfunction

  function automatic logic level_fall(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  assign cs_fall   = level_fall(cs_prev_q, cs_n_s);
  assign cs_rise   = level_rise(cs_prev_q, cs_n_s);
  assign sclk_rise = level_rise(sclk_prev_q, sclk_s);
  assign sclk_fall = level_fall(sclk_prev_q, sclk_s);

  // blanking timers, one per output so each output times out on its own
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_blank
    blank_timer u_blank (
      .clk     (CLK),
      .rst_n   (RST_N),
      .start   (blank_start[i]),
      .running (blank_run[i])
    );
  end

  // shared filter for the open-load comparators
  blank_timer u_fault_delay (
    .clk     (CLK),
    .rst_n   (RST_N),
    .start   (fault_start),
    .running (fault_run)
  );

  // status captured at frame start
  // read at the select fall, so it reflects the previous command word
  always_comb begin
    status_word = '0;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (cmd_q[i]) begin
        // off output: drain below threshold is an open load, once filtered
        status_word[i] = ~(~fault_run & ~drain_s[i]);
      end else begin
        // shutdown, thermal latch and current limit all read the same
        status_word[i] = ~gate_q[i] | ilim_q[i];
      end
    end
    if (ov_q) begin
      status_word = STATUS_ALL_OFF;
    end
  end

  // serial link: SI taken on SCLK fall, SO moves on SCLK rise
  always_comb begin
    frame_d     = frame_q;
    sr_d        = sr_q;
    cnt_d       = cnt_q;
    word_d      = word_q;
    so_d        = so_q;
    so_oe_d     = ~cs_n_s;
    cs_prev_d   = cs_n_s;
    sclk_prev_d = sclk_s;
    cmd_write   = 1'b0;
    if (luv_s) begin
      // frame in progress is dropped; nothing is trustworthy under low logic supply
      frame_d = FRAME_IDLE;
      sr_d    = STATUS_ALL_OFF;
      so_d    = 1'b1;
      cnt_d   = '0;
      word_d  = 1'b0;
    end else begin
      case (frame_q)
        FRAME_IDLE: begin
          if (cs_fall) begin
            frame_d = FRAME_ACTIVE;
            sr_d    = status_word;
            so_d    = status_word[WORD_BITS-1];
            cnt_d   = '0;
            word_d  = 1'b0;
          end
        end
        FRAME_ACTIVE: begin
          if (cs_rise) begin
            frame_d = FRAME_IDLE;
            // partial bytes are discarded; cascaded frames keep the last byte
            cmd_write = word_q && (cnt_q == '0);
          end else begin
            if (sclk_rise) begin
              // host samples on its falling edge, one clock after this update
              so_d = sr_q[WORD_BITS-1];
            end
            if (sclk_fall) begin
              sr_d  = {sr_q[WORD_BITS-2:0], si_s};
              cnt_d = 3'(cnt_q + 3'h1);
              if (cnt_q == BIT_CNT_LAST) begin
                word_d = 1'b1;
              end
            end
          end
        end
        default: frame_d = FRAME_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      frame_q     <= FRAME_IDLE;
      sr_q        <= STATUS_ALL_OFF;
      cnt_q       <= '0;
      word_q      <= 1'b0;
      so_q        <= 1'b1;
      so_oe_q     <= 1'b0;
      cs_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      frame_q     <= frame_d;
      sr_q        <= sr_d;
      cnt_q       <= cnt_d;
      word_q      <= word_d;
      so_q        <= so_d;
      so_oe_q     <= so_oe_d;
      cs_prev_q   <= cs_prev_d;
      sclk_prev_q <= sclk_prev_d;
    end
  end

  // output control
  always_comb begin
    cmd_d       = cmd_q;
    short_d     = short_q;
    therm_d     = therm_q | temp_s;
    ov_d        = ov_q | lov_s;
    blank_start = '0;
    fault_start = 1'b0;
    if (cmd_write) begin
      // load undervoltage has no input here: command always applies
      cmd_d       = sr_q;
      short_d     = '0;
      therm_d     = temp_s;
      ov_d        = lov_s;
      blank_start = ~sr_q;
    end
    // open-load filter restarts on every select rise, refused frames included
    if (cs_rise) begin
      fault_start = 1'b1;
    end
    // set after clear so a short on the write edge is not lost
    // drain_s lags the gate by the sync stages; blanking hides that lag
    for (int i = 0; i < NUM_OUT; i++) begin
      if (~sfsel_s && gate_q[i] && ~blank_run[i] && drain_s[i]) begin
        short_d[i] = 1'b1;
      end
    end
    if (luv_s) begin
      cmd_d   = CMD_ALL_OFF;
      short_d = '0;
    end
    // latches gate the output directly; select high never sets a short latch
    gate_d = ~cmd_d & ~short_d & ~therm_d & ~{NUM_OUT{ov_d}};
    ilim_d = {NUM_OUT{sfsel_s}} & gate_d & drain_s;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_q   <= CMD_ALL_OFF;
      short_q <= '0;
      therm_q <= '0;
      ov_q    <= 1'b0;
      gate_q  <= '0;
      ilim_q  <= '0;
    end else begin
      cmd_q   <= cmd_d;
      short_q <= short_d;
      therm_q <= therm_d;
      ov_q    <= ov_d;
      gate_q  <= gate_d;
      ilim_q  <= ilim_d;
    end
  end

  assign SO            = so_q;
  assign SO_OE         = so_oe_q;
  assign GATE_ON       = gate_q;
  assign CURRENT_LIMIT = ilim_q;

endmodule

/* test/switch_assertions.sv */
// Port-level checks on the octal switch shutdown block.
module switch_assertions (
  input wire logic                           CLK,
  input wire logic                           RST_N,
  input wire logic                           CHIP_SELECT_N,
  input wire logic                           SHORT_FAULT_SHUTDOWN_SELECT,
  input wire logic [switch_pkg::NUM_OUT-1:0] DRAIN_ABOVE_FAULT_THRESHOLD,
  input wire logic [switch_pkg::NUM_OUT-1:0] OVER_TEMP,
  input wire logic                           LOGIC_UNDERVOLTAGE,
  input wire logic                           LOAD_OVERVOLTAGE,
  input wire logic [switch_pkg::NUM_OUT-1:0] GATE_ON,
  input wire logic [switch_pkg::NUM_OUT-1:0] CURRENT_LIMIT
);
  import switch_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LATE = 680;
  logic [9:0] quiet_q;
  logic [9:0] quiet_d;
  wire logic  sel = SHORT_FAULT_SHUTDOWN_SELECT;
  // cycles since select rose; blanking is over well before LATE
  always_comb begin
    quiet_d = quiet_q;
    if (!CHIP_SELECT_N) quiet_d = '0;
    else if (quiet_q != 10'h3FF) quiet_d = quiet_q + 10'h001;
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) quiet_q <= '0;
    else quiet_q <= quiet_d;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_uv_off; LOGIC_UNDERVOLTAGE [*5] |-> GATE_ON == '0; endproperty
  a_uv_off: assert property (p_uv_off) else $error("gate on in undervoltage");
  property p_ov_off; LOAD_OVERVOLTAGE [*5] |-> GATE_ON == '0; endproperty
  a_ov_off: assert property (p_ov_off) else $error("gate on in overvoltage");
  property p_temp_off; $stable(OVER_TEMP) [*4] |-> (GATE_ON & OVER_TEMP) == '0; endproperty
  a_temp_off: assert property (p_temp_off) else $error("hot output on");
  property p_cl_mode; !sel [*5] |-> CURRENT_LIMIT == '0; endproperty
  a_cl_mode: assert property (p_cl_mode) else $error("limit in shutdown mode");
  property p_hold_hi;
    (sel && CHIP_SELECT_N && !LOAD_OVERVOLTAGE && !LOGIC_UNDERVOLTAGE && OVER_TEMP == '0) [*8]
      |-> $stable(GATE_ON);
  endproperty
  a_hold_hi: assert property (p_hold_hi) else $error("gate moved in limit mode");
  property p_late_short;
    not ((quiet_q > LATE && !sel && (GATE_ON & DRAIN_ABOVE_FAULT_THRESHOLD) != '0) [*8]);
  endproperty
  a_late_short: assert property (p_late_short) else $error("late short kept on");
  // faults only ever turn gates off, so the window must be flat without them
  property p_blank_hold;
    (quiet_q > 10'h00A && quiet_q < 10'h258 && !LOAD_OVERVOLTAGE && !LOGIC_UNDERVOLTAGE
      && OVER_TEMP == '0) |-> $stable(GATE_ON);
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("gate moved in blanking");
  property p_no_rise; quiet_q > 10'h00A |-> (GATE_ON & ~$past(GATE_ON)) == '0; endproperty
  a_no_rise: assert property (p_no_rise) else $error("gate on without write");
  c_limit: cover property (CURRENT_LIMIT != '0);
  c_late_off: cover property (quiet_q > LATE && $fell(GATE_ON[2]));
  c_ov: cover property (LOAD_OVERVOLTAGE && GATE_ON == '0);
endmodule

bind octal_switch_fault_shutdown switch_assertions chk (
  .CLK(CLK), .RST_N(RST_N), .CHIP_SELECT_N(CHIP_SELECT_N),
  .SHORT_FAULT_SHUTDOWN_SELECT(SHORT_FAULT_SHUTDOWN_SELECT),
  .DRAIN_ABOVE_FAULT_THRESHOLD(DRAIN_ABOVE_FAULT_THRESHOLD), .OVER_TEMP(OVER_TEMP),
  .LOGIC_UNDERVOLTAGE(LOGIC_UNDERVOLTAGE), .LOAD_OVERVOLTAGE(LOAD_OVERVOLTAGE),
  .GATE_ON(GATE_ON), .CURRENT_LIMIT(CURRENT_LIMIT));

/* test/host_link.sv */
// Host side of the serial link: sends one command word, collects status.
module host_link (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] cmd,
  input  wire logic       so_line,
  output logic            cs_n,
  output logic            sclk,
  output logic            si,
  output logic [7:0]      status,
  output logic            done
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    status = 8'h00;
    done = 1'b0;
  end
  // 320 ns per bit; si moves mid-high so it never races the sampled fall
  always @(posedge clk) begin
    if (go && !done) begin
      cs_n <= 1'b0;
      repeat (6) @(posedge clk);
      for (int i = 7; i >= 0; i--) begin
        sclk <= 1'b1;
        repeat (2) @(posedge clk);
        si <= cmd[i];
        repeat (2) @(posedge clk);
        // so moves on the rise the device detects; take it as sclk falls
        status[i] <= so_line;
        sclk <= 1'b0;
        repeat (4) @(posedge clk);
      end
      cs_n <= 1'b1;
      repeat (6) @(posedge clk);
      done <= 1'b1;
    end else begin
      si <= ~si;
      if (!go) done <= 1'b0;
    end
  end
endmodule

/* test/testbench.sv */
// Self-checking bench for the octal switch fault and shutdown logic.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       go = 1'b0;
  logic       sel = 1'b0;
  logic       luv = 1'b0;
  logic       lov = 1'b0;
  logic [7:0] cmd = 8'hFF;
  logic [7:0] drain = 8'hFF;
  logic [7:0] temp = 8'h00;
  logic [7:0] short_m = 8'h00;
  logic [7:0] open_m = 8'h00;
  logic       cs_n, sclk, si, so, so_oe, done;
  logic [7:0] gate, climit, st;
  int         n_fail = 0;
  int         tests_run = 0;
  // undriven line shows the opposite level so a stale bit cannot pass
  wire logic  so_line = so_oe ? so : ~so;
  always #20 clk = ~clk;
  // load model: a conducting gate pulls its drain low
  always @(posedge clk) drain <= (~gate & ~open_m) | short_m;
  octal_switch_fault_shutdown dut (
    .CLK(clk), .RST_N(rst_n), .CHIP_SELECT_N(cs_n), .SCLK(sclk), .SI(si), .SO(so),
    .SO_OE(so_oe), .SHORT_FAULT_SHUTDOWN_SELECT(sel), .DRAIN_ABOVE_FAULT_THRESHOLD(drain),
    .OVER_TEMP(temp), .LOGIC_UNDERVOLTAGE(luv), .LOAD_OVERVOLTAGE(lov), .GATE_ON(gate),
    .CURRENT_LIMIT(climit));
  host_link host (.clk(clk), .go(go), .cmd(cmd), .so_line(so_line), .cs_n(cs_n),
    .sclk(sclk), .si(si), .status(st), .done(done));
  task automatic wrap_up;
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] c);
    int k;
    cmd <= c;
    go <= 1'b1;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      if (done === 1'b1) break;
    end
    if (done !== 1'b1) begin
      n_fail++;
      $display("BAD frame done expected 1 seen %b", done);
      wrap_up();
    end
    go <= 1'b0;
    @(posedge clk);
  endtask
  task automatic basic;
    frame(8'hF0);
    chk("reset status", 8'hFF, st);
    idle(300);
    chk("gates", 8'h0F, gate);
    idle(400);
    frame(8'hF0);
    chk("healthy status", 8'hF0, st);
  endtask
  task automatic open_load;
    open_m <= 8'h80;
    frame(8'hF0);
    chk("filtered open", 8'hF0, st);
    idle(700);
    frame(8'hF0);
    chk("open load", 8'h80, (st ^ 8'hF0) & 8'hF0);
    open_m <= 8'h00;
  endtask
  task automatic short_on;
    short_m <= 8'h10;
    frame(8'hE0);
    idle(300);
    chk("blanked short", 8'h1F, gate);
    idle(400);
    chk("short off", 8'h0F, gate);
    frame(8'hE0);
    idle(300);
    chk("retry on", 8'h1F, gate);
    idle(400);
    chk("retry off", 8'h0F, gate);
    short_m <= 8'h00;
    idle(50);
    chk("stays off", 8'h0F, gate);
  endtask
  task automatic short_mid;
    frame(8'hF0);
    idle(100);
    short_m <= 8'h02;
    idle(200);
    chk("mid short", 8'h0F, gate);
    idle(400);
    chk("mid short off", 8'h0D, gate);
    short_m <= 8'h04;
    idle(10);
    chk("late short", 8'h09, gate);
    short_m <= 8'h00;
    frame(8'hF0);
    chk("short status", 8'hF6, st);
    idle(700);
  endtask
  task automatic limit;
    sel <= 1'b1;
    short_m <= 8'h04;
    idle(10);
    chk("limited gate", 8'h0F, gate);
    chk("limit flag", 8'h04, climit);
    short_m <= 8'h00;
    idle(10);
    chk("limit gone", 8'h00, climit);
    chk("limit recovered", 8'h0F, gate);
  endtask
  task automatic thermal;
    temp <= 8'h08;
    idle(10);
    chk("hot off", 8'h07, gate);
    frame(8'hF0);
    chk("hot status", 8'hF8, st);
    temp <= 8'h00;
    idle(700);
    chk("hot latched", 8'h07, gate);
    frame(8'hF0);
    idle(700);
    chk("hot cleared", 8'h0F, gate);
  endtask
  task automatic overvolt;
    sel <= 1'b0;
    lov <= 1'b1;
    idle(10);
    chk("ov off", 8'h00, gate);
    lov <= 1'b0;
    idle(10);
    chk("ov latched", 8'h00, gate);
    frame(8'hF0);
    chk("ov status", 8'hFF, st);
    idle(700);
    chk("ov cleared", 8'h0F, gate);
  endtask
  task automatic undervolt;
    luv <= 1'b1;
    idle(10);
    chk("uv off", 8'h00, gate);
    luv <= 1'b0;
    idle(10);
    frame(8'h00);
    chk("uv status", 8'hFF, st);
    idle(300);
    chk("all on", 8'hFF, gate);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    idle(5);
    basic();
    open_load();
    short_on();
    short_mid();
    limit();
    thermal();
    overvolt();
    undervolt();
    wrap_up();
  end
endmodule
